/* File: design/rxfc_map.vh */
// Purpose: register map and field positions of the receive config bank
// Assumes: byte registers, one per aligned 32-bit APB word
// Notes: port n copy sits at base plus n times the port stride
`ifndef RXFC_MAP_VH
`define RXFC_MAP_VH
`define RXFC_OFF_SA5 12'h06a
`define RXFC_OFF_SA6 12'h06b
`define RXFC_OFF_SA7 12'h06c
`define RXFC_OFF_SA8 12'h06d
`define RXFC_OFF_LAST 12'h06e
`define RXFC_OFF_CODE 12'h06f
`define RXFC_OFF_MMR 12'h080
`define RXFC_OFF_RC1 12'h081
`define RXFC_OFF_MON 12'h070
`define RXFC_PORT_STRIDE 12'h200
`define RXFC_NPORTS 4
`define RXFC_MM_FRAMER_ON 7
`define RXFC_MM_INIT_DONE 6
`define RXFC_MM_SOFT_RST 1
`define RXFC_MM_STD_SEL 0
`define RXFC_RC1_B7 7
`define RXFC_RC1_B6 6
`define RXFC_RC1_B5 5
`define RXFC_RC1_B4 4
`define RXFC_RC1_B3 3
`define RXFC_RC1_B2 2
`define RXFC_RC1_INHIBIT 1
`define RXFC_RC1_RESYNC 0
`define RXFC_MMR_MASK 8'hc3
`define RXFC_RC1_E1_MASK 8'h7f
`define RXFC_MON_MASK 8'h1f
`define RXFC_RESET_BYTE 8'h00
`endif

/* File: design/rxfc_port.v */
// Purpose: one port's Sa capture and receive control byte store
// Assumes: Sa strobes come from framer logic on pclk
// Notes: Sa5 to Sa8 capture bytes swap in as a whole set per multiframe; last bits and code update per strobe
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_map.vh"
module rxfc_port (
    input wire pclk,
    input wire presetn,
    input wire wr_en,
    input wire [11:0] wr_off,
    input wire [7:0] wr_data,
    input wire [11:0] rd_off,
    output reg [7:0] rd_data,
    input wire sa_valid,
    input wire [2:0] sa_frame_idx,
    input wire [4:0] sa_bits,
    input wire mf_end,
    output wire [7:0] mode_q,
    output wire [7:0] ctrl_q,
    output reg resync_pulse_q,
    output reg sa_change_q
);
    reg [7:0] mmr_q;
    reg [7:0] rc1_q;
    reg [7:0] mon_q;
    reg [4:0] last_q;
    reg [3:0] code_q;
    reg [7:0] shad_q [0:3];
    reg [7:0] frm_q [0:3];
    wire e1 = mmr_q[`RXFC_MM_STD_SEL];
    wire [4:0] chg = (sa_bits ^ last_q) & mon_q[4:0];
    integer i;

    assign mode_q = mmr_q;
    assign ctrl_q = rc1_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mmr_q <= `RXFC_RESET_BYTE;
            rc1_q <= `RXFC_RESET_BYTE;
            mon_q <= `RXFC_RESET_BYTE;
            resync_pulse_q <= 1'b0;
        end else begin
            // rising edge of bit0 only; host must clear it between requests
            resync_pulse_q <= wr_en && wr_off == `RXFC_OFF_RC1 &&
                wr_data[`RXFC_RC1_RESYNC] &&
                !rc1_q[`RXFC_RC1_RESYNC];
            if (wr_en && wr_off == `RXFC_OFF_MMR)
                mmr_q <= wr_data & `RXFC_MMR_MASK;
            if (wr_en && wr_off == `RXFC_OFF_RC1)
                rc1_q <= e1 ? (wr_data & `RXFC_RC1_E1_MASK)
                            : wr_data;
            if (wr_en && wr_off == `RXFC_OFF_MON)
                mon_q <= wr_data & `RXFC_MON_MASK;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 5'h00;
            code_q <= 4'h0;
            sa_change_q <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                shad_q[i] <= `RXFC_RESET_BYTE;
                frm_q[i] <= `RXFC_RESET_BYTE;
            end
        end else begin
            sa_change_q <= sa_valid && (chg != 5'h00);
            if (sa_valid) begin
                last_q <= sa_bits;
                // shift in unaligned; any rotation may be reported
                code_q <= {code_q[2:0], sa_bits[2]};
                for (i = 0; i < 4; i = i + 1)
                    shad_q[i][sa_frame_idx] <= sa_bits[3 - i];
            end
            if (mf_end) begin
                for (i = 0; i < 4; i = i + 1)
                    frm_q[i] <= shad_q[i];
            end
        end
    end

    // reads have no side effect; capture bytes have no write path
    always @* begin
        case (rd_off)
            `RXFC_OFF_SA5: rd_data = frm_q[0];
            `RXFC_OFF_SA6: rd_data = frm_q[1];
            `RXFC_OFF_SA7: rd_data = frm_q[2];
            `RXFC_OFF_SA8: rd_data = frm_q[3];
            `RXFC_OFF_LAST: rd_data = {3'h0, last_q};
            `RXFC_OFF_CODE: rd_data = {4'h0, code_q};
            `RXFC_OFF_MMR: rd_data = mmr_q;
            `RXFC_OFF_RC1: rd_data = rc1_q;
            `RXFC_OFF_MON: rd_data = mon_q;
            default: rd_data = 8'h00;
        endcase
    end
endmodule // rxfc_port
`default_nettype wire

/* File: design/rxfc_top.v */
// Purpose: four-port receive config and Sa capture bank on APB
// Assumes: pclk 25 MHz; Sa strobes synchronous to pclk
// Notes: zero-wait APB, pslverr on unmapped address
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_map.vh"
module rxfc_top #(
    parameter NPORTS = `RXFC_NPORTS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [NPORTS-1:0] sa_valid,
    input wire [3*NPORTS-1:0] sa_frame_idx,
    input wire [5*NPORTS-1:0] sa_bits,
    input wire [NPORTS-1:0] mf_end,
    output reg [NPORTS-1:0] framer_on,
    output reg [NPORTS-1:0] framer_run,
    output reg [NPORTS-1:0] receiver_soft_reset,
    output reg [NPORTS-1:0] line_standard_select,
    output reg [NPORTS-1:0] sync_qualify_length,
    output reg [NPORTS-1:0] rx_zero_sub_enable,
    output reg [NPORTS-1:0] rx_framing_format,
    output reg [NPORTS-1:0] auto_resync_trigger,
    output reg [NPORTS-1:0] sync_search_criteria,
    output reg [NPORTS-1:0] japan_crc_select,
    output reg [NPORTS-1:0] auto_resync_inhibit,
    output reg [NPORTS-1:0] rx_hdb_decode_enable,
    output reg [NPORTS-1:0] signaling_mode_select,
    output reg [NPORTS-1:0] slot26_blank_enable,
    output reg [NPORTS-1:0] multiframe_crc_enable,
    output reg [NPORTS-1:0] frame_resync_criteria,
    output reg [NPORTS-1:0] resync_start,
    output reg [NPORTS-1:0] sa_change
);
    // byte address = printed offset * 4, since offsets are not word aligned
    wire [13:0] word = paddr[15:2];
    wire [1:0] port_sel = word[10:9];
    wire [11:0] off = {3'h0, word[8:0]};
    // bits above the port field must be clear, else copies would alias
    wire hi_zero = (paddr[31:13] == 19'h00000) && (paddr[1:0] == 2'b00);
    wire setup = psel && !penable;
    wire [NPORTS*8-1:0] rd_all;
    wire [NPORTS*8-1:0] mode_all;
    wire [NPORTS*8-1:0] ctrl_all;
    wire [NPORTS-1:0] pulse_all;
    wire [NPORTS-1:0] chg_all;
    reg [7:0] rd_sel;
    integer k;
    integer j;

    function mapped;
        input [11:0] o;
        begin
            mapped = (o >= `RXFC_OFF_SA5 && o <= `RXFC_OFF_MON) ||
                o == `RXFC_OFF_MMR || o == `RXFC_OFF_RC1;
        end
    endfunction

    wire addr_ok = hi_zero && ({1'b0, port_sel} < NPORTS) && mapped(off);

    genvar g;
    generate
        for (g = 0; g < NPORTS; g = g + 1) begin : g_port
            rxfc_port u_port (
                .pclk(pclk),
                .presetn(presetn),
                // write lands only at the edge that completes the access
                .wr_en(psel && penable && pready && pwrite && addr_ok &&
                    port_sel == g),
                .wr_off(off),
                .wr_data(pwdata[7:0]),
                .rd_off(off),
                .rd_data(rd_all[g*8 +: 8]),
                .sa_valid(sa_valid[g]),
                .sa_frame_idx(sa_frame_idx[g*3 +: 3]),
                .sa_bits(sa_bits[g*5 +: 5]),
                .mf_end(mf_end[g]),
                .mode_q(mode_all[g*8 +: 8]),
                .ctrl_q(ctrl_all[g*8 +: 8]),
                .resync_pulse_q(pulse_all[g]),
                .sa_change_q(chg_all[g])
            );
        end
    endgenerate

    always @* begin
        rd_sel = 8'h00;
        for (j = 0; j < NPORTS; j = j + 1)
            if (port_sel == j)
                rd_sel = rd_all[j*8 +: 8];
    end

    // answer registered in setup, so access phase completes at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_ok;
            if (setup && !pwrite)
                prdata <= addr_ok ? {24'h000000, rd_sel} : 32'h00000000;
        end
    end

    // per-port control outputs, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            framer_on <= {NPORTS{1'b0}};
            framer_run <= {NPORTS{1'b0}};
            receiver_soft_reset <= {NPORTS{1'b0}};
            line_standard_select <= {NPORTS{1'b0}};
            sync_qualify_length <= {NPORTS{1'b0}};
            rx_zero_sub_enable <= {NPORTS{1'b0}};
            rx_framing_format <= {NPORTS{1'b0}};
            auto_resync_trigger <= {NPORTS{1'b0}};
            sync_search_criteria <= {NPORTS{1'b0}};
            japan_crc_select <= {NPORTS{1'b0}};
            auto_resync_inhibit <= {NPORTS{1'b0}};
            rx_hdb_decode_enable <= {NPORTS{1'b0}};
            signaling_mode_select <= {NPORTS{1'b0}};
            slot26_blank_enable <= {NPORTS{1'b0}};
            multiframe_crc_enable <= {NPORTS{1'b0}};
            frame_resync_criteria <= {NPORTS{1'b0}};
            resync_start <= {NPORTS{1'b0}};
            sa_change <= {NPORTS{1'b0}};
        end else begin
            for (k = 0; k < NPORTS; k = k + 1) begin
                framer_on[k] <= mode_all[k*8+`RXFC_MM_FRAMER_ON];
                // runs only once init done seen with enable set
                framer_run[k] <= mode_all[k*8+`RXFC_MM_INIT_DONE] &&
                    mode_all[k*8+`RXFC_MM_FRAMER_ON] &&
                    !mode_all[k*8+`RXFC_MM_SOFT_RST];
                receiver_soft_reset[k] <=
                    mode_all[k*8+`RXFC_MM_SOFT_RST];
                line_standard_select[k] <=
                    mode_all[k*8+`RXFC_MM_STD_SEL];
                // T1 field outputs driven zero in E1 mode and vice versa
                if (!mode_all[k*8+`RXFC_MM_STD_SEL]) begin
                    sync_qualify_length[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B7];
                    rx_zero_sub_enable[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B6];
                    rx_framing_format[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B5];
                    auto_resync_trigger[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B4];
                    sync_search_criteria[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B3];
                    japan_crc_select[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B2];
                    rx_hdb_decode_enable[k] <= 1'b0;
                    signaling_mode_select[k] <= 1'b0;
                    slot26_blank_enable[k] <= 1'b0;
                    multiframe_crc_enable[k] <= 1'b0;
                    frame_resync_criteria[k] <= 1'b0;
                end else begin
                    sync_qualify_length[k] <= 1'b0;
                    rx_zero_sub_enable[k] <= 1'b0;
                    rx_framing_format[k] <= 1'b0;
                    auto_resync_trigger[k] <= 1'b0;
                    sync_search_criteria[k] <= 1'b0;
                    japan_crc_select[k] <= 1'b0;
                    rx_hdb_decode_enable[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B6];
                    signaling_mode_select[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B5];
                    slot26_blank_enable[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B4];
                    multiframe_crc_enable[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B3];
                    frame_resync_criteria[k] <=
                        ctrl_all[k*8+`RXFC_RC1_B2];
                end
                auto_resync_inhibit[k] <=
                    ctrl_all[k*8+`RXFC_RC1_INHIBIT];
                resync_start[k] <= pulse_all[k];
                sa_change[k] <= chg_all[k];
            end
        end
    end
endmodule // rxfc_top
`default_nettype wire

/* File: tb/rxfc_assertions.sv */
// Purpose: port checks bound into the receive config bank
// Assumes: port 0 carries mode traffic, port 2 carries Sa traffic
// Notes: apb answers one cycle after the setup edge
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_map.vh"
module rxfc_assertions #(
    parameter NPORTS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NPORTS-1:0] sa_valid,
    input wire logic [NPORTS-1:0] framer_on,
    input wire logic [NPORTS-1:0] framer_run,
    input wire logic [NPORTS-1:0] receiver_soft_reset,
    input wire logic [NPORTS-1:0] line_standard_select,
    input wire logic [NPORTS-1:0] sync_qualify_length,
    input wire logic [NPORTS-1:0] rx_hdb_decode_enable,
    input wire logic [NPORTS-1:0] resync_start,
    input wire logic [NPORTS-1:0] sa_change
);
    wire logic wr_setup = psel & ~penable & pwrite;
    wire logic mmr0 = paddr == {18'h0, `RXFC_OFF_MMR, 2'b00};
    wire logic rs_req = wr_setup & pwdata[0] &
        (paddr == {18'h0, `RXFC_OFF_RC1, 2'b00});
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_next;
        psel && !penable |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("lone error");
    // bit 1 too, so a stuck soft reset shows
    property p_mode_follow;
        wr_setup && mmr0 |-> ##3 framer_on[0] == $past(pwdata[7], 3) &&
            receiver_soft_reset[0] == $past(pwdata[1], 3) &&
            line_standard_select[0] == $past(pwdata[0], 3);
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode lag");
    property p_run_gate;
        framer_run[0] |-> framer_on[0] && !receiver_soft_reset[0];
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("run ungated");
    property p_resync_cause;
        resync_start[0] |-> $past(rs_req, 3);
    endproperty
    a_resync_cause: assert property (p_resync_cause) else $error("resync");
    property p_e1_no_t1;
        line_standard_select[0] |-> !sync_qualify_length[0];
    endproperty
    a_e1_no_t1: assert property (p_e1_no_t1) else $error("t1 in e1");
    property p_t1_no_e1;
        !line_standard_select[0] |-> !rx_hdb_decode_enable[0];
    endproperty
    a_t1_no_e1: assert property (p_t1_no_e1) else $error("e1 in t1");
    property p_change_cause;
        sa_change[2] |-> $past(sa_valid[2], 2);
    endproperty
    a_change_cause: assert property (p_change_cause) else $error("change");
    c_mode: cover property (wr_setup && mmr0);
    c_resync: cover property (resync_start[0]);
    c_change: cover property (sa_change[2]);
endmodule // rxfc_assertions
bind rxfc_top rxfc_assertions #(.NPORTS(NPORTS)) rxfc_assertions_i (.*);
`default_nettype wire

/* File: tb/rxfc_top_bench.sv */
// Purpose: self-checking bench for the receive config bank
// Assumes: one apb word per byte register
// Notes: Sa traffic only on port 2
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_map.vh"
module rxfc_top_bench;
    typedef struct {logic [31:0] a; logic [7:0] d, x; logic e;} rxfc_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [31:0] paddr = 0, pwdata = 0, q;
    logic [3:0] sa_valid = 0, mf_end = 0, cw;
    logic [11:0] sa_frame_idx = 0;
    logic [19:0] sa_bits = 0;
    logic [4:0] sb, prev;
    logic [7:0] sx [4] = '{8'ha5, 8'h3c, 8'hf0, 8'h96};
    int err_total = 0, check_count = 0, cyc = 0, rs_n = 0, ch_n = 0, n_exp;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [3:0] framer_on, framer_run, receiver_soft_reset, line_standard_select;
    wire [3:0] sync_qualify_length, rx_zero_sub_enable, rx_framing_format;
    wire [3:0] auto_resync_trigger, sync_search_criteria, japan_crc_select;
    wire [3:0] auto_resync_inhibit, rx_hdb_decode_enable, signaling_mode_select;
    wire [3:0] slot26_blank_enable, multiframe_crc_enable, frame_resync_criteria;
    wire [3:0] resync_start, sa_change;
    wire [3:0] p0_mode = {framer_on[0], receiver_soft_reset[0],
        line_standard_select[0], framer_run[0]};
    wire [6:0] p1_t1 = {sync_qualify_length[1], rx_zero_sub_enable[1],
        rx_framing_format[1], auto_resync_trigger[1], sync_search_criteria[1],
        japan_crc_select[1], auto_resync_inhibit[1]};
    wire [6:0] p0_e1 = {rx_hdb_decode_enable[0], signaling_mode_select[0],
        slot26_blank_enable[0], multiframe_crc_enable[0],
        frame_resync_criteria[0], auto_resync_inhibit[0], sync_qualify_length[0]};
    rxfc_row_t rows [6];
    rxfc_top #(.NPORTS(4)) rxfc_top_i (.*);
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (resync_start[1] === 1'b1) rs_n++;
        if (sa_change[2] === 1'b1) ch_n++;
        if (cyc == 3000) begin
            err_total++;
            end_of_test;
        end
    end
    function automatic logic [31:0] ad(input int p, input logic [11:0] o);
        return {18'h0, o, 2'b00} + p * 32'h800;
    endfunction
    // host side decode of a reported codeword pattern
    function automatic logic [3:0] sa6_decode(input logic [3:0] p);
        case (p)
            4'h1, 4'h2, 4'h4, 4'h8: return 4'h8;
            4'h5, 4'ha: return 4'ha;
            4'h3, 4'h6, 4'h9, 4'hc: return 4'hc;
            4'h7, 4'hb, 4'hd, 4'he: return 4'he;
            4'hf: return 4'hf;
            default: return 4'h0;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a,
            input logic [7:0] d, output logic [31:0] rq, output logic re);
        int n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) err_total++;
        rq = prdata;
        re = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        for (int k = 0; k < 9; k++) begin
            apb(0, ad(1, k < 7 ? `RXFC_OFF_SA5 + k : `RXFC_OFF_MMR + k - 7),
                8'h00, q, e);
            chk("reset value", q, 0);
        end
        $display("reset values done");
        rows = '{'{ad(0, `RXFC_OFF_MMR), 8'hff, 8'hc3, 0},
                 '{ad(3, `RXFC_OFF_MMR), 8'h01, 8'h01, 0},
                 '{ad(1, `RXFC_OFF_RC1), 8'hfe, 8'hfe, 0},
                 '{ad(0, `RXFC_OFF_RC1), 8'hff, 8'h7f, 0},
                 '{ad(2, `RXFC_OFF_SA6), 8'hff, 8'h00, 0},
                 '{ad(0, 12'h0f0), 8'h5a, 8'h00, 1}};
        foreach (rows[r]) begin
            apb(1, rows[r].a, rows[r].d, q, e);
            apb(0, rows[r].a, 8'h00, q, e);
            chk("row read", q, rows[r].x);
            chk("row error", e, rows[r].e);
        end
        chk("port0 mode", p0_mode, 4'he);
        chk("port1 t1", p1_t1, 7'h7f);
        chk("port0 e1", p0_e1, 7'h7e);
        apb(1, ad(0, `RXFC_OFF_MMR), 8'hc1, q, e);
        repeat (3) @(posedge pclk);
        chk("port0 run", framer_run[0], 1);
        $display("table and mode done");
        // second write of one in a row must not start another resync pulse
        foreach (sx[k]) apb(1, ad(1, `RXFC_OFF_RC1), k == 2 ? 8'hfe : 8'hff, q, e);
        repeat (4) @(posedge pclk);
        chk("resync pulses", rs_n, 2);
        $display("resync done");
        apb(1, ad(2, `RXFC_OFF_MON), 8'h1e, q, e);
        prev = 0;
        cw = 0;
        n_exp = 0;
        for (int i = 0; i < 8; i++) begin
            sb = {i[2], sx[0][i], sx[1][i], sx[2][i], sx[3][i]};
            if (((sb ^ prev) & 5'h1e) != 0) n_exp++;
            prev = sb;
            cw = {cw[2:0], sb[2]};
            @(posedge pclk);
            sa_valid[2] <= 1;
            sa_frame_idx[8:6] <= i[2:0];
            sa_bits[14:10] <= sb;
            @(posedge pclk);
            sa_valid[2] <= 0;
        end
        repeat (3) @(posedge pclk);
        chk("sa changes", ch_n, n_exp);
        apb(0, ad(2, `RXFC_OFF_SA6), 8'h00, q, e);
        chk("sa6 before end", q, 0);
        @(posedge pclk);
        mf_end[2] <= 1;
        @(posedge pclk);
        mf_end[2] <= 0;
        foreach (sx[k]) begin
            apb(0, ad(2, `RXFC_OFF_SA5 + k), 8'h00, q, e);
            chk("sa byte", q, sx[k]);
        end
        apb(0, ad(2, `RXFC_OFF_LAST), 8'h00, q, e);
        chk("last bits", q, prev);
        apb(0, ad(2, `RXFC_OFF_CODE), 8'h00, q, e);
        chk("codeword", q, cw);
        chk("sa6 code", sa6_decode(q[3:0]), 4'hc);
        $display("sa capture done");
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        chk("on in reset", framer_on[0], 0);
        presetn <= 1;
        apb(0, ad(0, `RXFC_OFF_MMR), 8'h00, q, e);
        chk("mode after reset", q, 0);
        $display("second reset done");
        end_of_test;
    end
endmodule // rxfc_top_bench
`default_nettype wire
